// File: core/cfg_pkg.sv
// package: offsets, field positions, reset values and timing counts of the motion config bank
`default_nettype none
package cfg_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [7:0] ORIENT_SETUP_ADDR   = 8'h2c;
  localparam logic [7:0] ORIENT_ANGLE_ADDR   = 8'h2d;
  localparam logic [7:0] FLAT_ANGLE_ADDR     = 8'h2e;
  localparam logic [7:0] FLAT_HOLD_ADDR      = 8'h2f;
  localparam logic [7:0] QUEUE_WM_ADDR       = 8'h30;
  localparam logic [7:0] SELFTEST_ADDR       = 8'h32;
  localparam logic [7:0] ORIENT_SETUP_RESET  = 8'h18;
  localparam logic [7:0] ORIENT_ANGLE_RESET  = 8'h48;
  localparam logic [7:0] FLAT_ANGLE_RESET    = 8'h08;
  localparam logic [7:0] FLAT_HOLD_RESET     = 8'h11;
  localparam logic [7:0] QUEUE_WM_RESET      = 8'h00;
  localparam logic [7:0] SELFTEST_RESET      = 8'h00;
  // writable bits; reserved bits are stored as zero and read as zero
  localparam logic [7:0] ORIENT_SETUP_MASK   = 8'h7f;
  localparam logic [7:0] ORIENT_ANGLE_MASK   = 8'h7f;
  localparam logic [7:0] FLAT_ANGLE_MASK     = 8'h3f;
  localparam logic [7:0] FLAT_HOLD_MASK      = 8'h37;
  localparam logic [7:0] QUEUE_WM_MASK       = 8'h3f;
  localparam logic [7:0] SELFTEST_MASK       = 8'h0f;
  localparam int unsigned HYST_POS      = 4;
  localparam int unsigned BLOCK_POS     = 2;
  localparam int unsigned MODE_POS      = 0;
  localparam int unsigned UD_EN_POS     = 6;
  localparam int unsigned THETA_POS     = 0;
  localparam int unsigned HOLD_POS      = 4;
  localparam int unsigned LEVEL_HY_POS  = 0;
  localparam int unsigned WM_POS        = 0;
  localparam int unsigned AMP_POS       = 3;
  localparam int unsigned SIGN_POS      = 2;
  localparam int unsigned AXIS_POS      = 0;
  // hysteresis step in micro-g, fixed for every range
  localparam int unsigned HYST_STEP_UG  = 62500;
  localparam int unsigned STABLE_MS     = 100;
  localparam int unsigned HOLD_UNIT_MS  = 512;
  localparam int unsigned SETTLE_MS     = 50;
  // 1 ms tick from the reference clock
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
  localparam logic [14:0] MS_LAST       = 15'(MS_CYCLES - 1);
  localparam logic [11:0] STABLE_LAST   = 12'(STABLE_MS);
  localparam logic [11:0] SETTLE_LAST   = 12'(SETTLE_MS);
endpackage : cfg_pkg
`default_nettype wire

// File: core/cfg_if.sv
// interface: decoded configuration fields shared by the bank and its timer
`default_nettype none
interface cfg_if;
  logic       ms_tick;
  logic [1:0] hold_code;
  logic       flat_change;
  logic [1:0] block_mode;
  logic       orient_change;
  logic [1:0] axis;
  logic       flat_hold_done;
  logic       orient_stable;
  logic       selftest_settled;
  modport bank  (output hold_code, flat_change, block_mode, orient_change, axis,
                 input ms_tick, flat_hold_done, orient_stable, selftest_settled);
  modport timer (input hold_code, flat_change, block_mode, orient_change, axis,
                 output ms_tick, flat_hold_done, orient_stable, selftest_settled);
endinterface : cfg_if
`default_nettype wire

// File: core/cfg_timer.sv
// millisecond timers: flat hold, orientation stability and self-test settling
`default_nettype none
module cfg_timer (
  input  wire logic i_ref_clk, // 25 MHz clock
  input  wire logic i_reset,   // sync reset, active high
  cfg_if.timer      c          // decoded fields and timer flags
);
  logic [14:0] div_reg;
  logic [11:0] hold_reg;
  logic [11:0] stab_reg;
  logic [11:0] settle_reg;
  logic [11:0] hold_last;
  logic        st_on;

  // code 00 means no hold at all; 01..11 double from the base unit
  assign hold_last = (c.hold_code == 2'h0) ? 12'h0
                   : 12'(cfg_pkg::HOLD_UNIT_MS) << (c.hold_code - 2'h1);
  assign st_on     = c.axis != 2'h0;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || div_reg == cfg_pkg::MS_LAST) div_reg <= 15'h0;
    else div_reg <= div_reg + 15'h1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) c.ms_tick <= 1'b0;
    else c.ms_tick <= div_reg == cfg_pkg::MS_LAST;
  end

  // hold restarts on every flat change; code 00 needs no wait
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || c.flat_change) hold_reg <= 12'h0;
    else if (c.ms_tick && hold_reg < hold_last) hold_reg <= hold_reg + 12'h1;
  end
  assign c.flat_hold_done = (hold_reg >= hold_last) && !c.flat_change;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || c.orient_change) stab_reg <= 12'h0;
    else if (c.ms_tick && stab_reg < cfg_pkg::STABLE_LAST) stab_reg <= stab_reg + 12'h1;
  end
  assign c.orient_stable = stab_reg >= cfg_pkg::STABLE_LAST;

  // settle counter only informs the host; waiting is the host's job
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !st_on) settle_reg <= 12'h0;
    else if (c.ms_tick && settle_reg < cfg_pkg::SETTLE_LAST) settle_reg <= settle_reg + 12'h1;
  end
  assign c.selftest_settled = st_on && settle_reg >= cfg_pkg::SETTLE_LAST;

  a_stable_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    c.orient_change |=> !c.orient_stable) else $error("orientation stable after change");
  a_hold_zero: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (c.hold_code == 2'h0 && !c.flat_change) |-> c.flat_hold_done) else $error("hold 0 waits");
endmodule : cfg_timer
`default_nettype wire

// File: core/motion_cfg_regs.sv
// top: motion feature configuration register bank with blocking and qualifier logic
`default_nettype none
module motion_cfg_regs (
  input  wire logic       i_ref_clk,       // 25 MHz clock
  input  wire logic       i_reset,         // sync reset, active high
  input  wire logic       i_wr_en,         // register write strobe
  input  wire logic       i_rd_en,         // register read strobe
  input  wire logic [7:0] i_addr,          // register address
  input  wire logic [7:0] i_wdata,         // write data
  input  wire logic       i_theta_block,   // engine: tilt inside theta cone
  input  wire logic       i_slope_02g,     // engine: slope above 0.2 g
  input  wire logic       i_slope_04g,     // engine: slope above 0.4 g
  input  wire logic       i_accel_15g,     // engine: axis above 1.5 g
  input  wire logic       i_orient_event,  // engine: orientation value changed
  input  wire logic       i_updown_change, // engine: up/down bit changed
  input  wire logic [7:0] i_flat_delta,    // engine: flat value movement
  input  wire logic       i_flat_event,    // engine: raw flat state candidate
  input  wire logic [6:0] i_fifo_count,    // queue entry count
  output logic      [7:0] o_rdata,         // read data
  output logic      [2:0] o_orient_hyst,   // hysteresis steps of 62.5 mg
  output logic      [1:0] o_orient_mode,   // threshold mode
  output logic      [5:0] o_orient_theta,  // blocking angle code
  output logic      [5:0] o_flat_theta,    // flat angle code
  output logic            o_orient_irq,    // orientation interrupt pulse
  output logic            o_flat_irq,      // flat interrupt pulse
  output logic            o_wm_irq,        // watermark interrupt pulse
  output logic      [2:0] o_st_axis_valid, // per-axis readout valid (x,y,z)
  output logic            o_st_excite,     // self-test excitation on
  output logic            o_st_positive,   // self-test sign
  output logic            o_st_high_amp,   // self-test high amplitude
  output logic            o_st_settled     // self-test settle time passed
);
  logic [7:0] orient_setup_reg;
  logic [7:0] orient_angle_reg;
  logic [7:0] flat_angle_reg;
  logic [7:0] flat_hold_reg;
  logic [7:0] queue_wm_reg;
  logic [7:0] selftest_reg;
  logic [1:0] block_mode;
  logic [2:0] level_hysteresis;
  logic       updown_change_irq_enable;
  logic [5:0] wm_level;
  logic [1:0] st_axis;
  logic       blocked;
  logic       orient_src;
  logic       flat_change;
  logic       flat_pend_reg;
  logic       wm_hit_reg;
  logic [8:0] flat_limit;
  cfg_if      c ();

  // configuration writes; reserved bits never stored
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      orient_setup_reg <= cfg_pkg::ORIENT_SETUP_RESET;
      orient_angle_reg <= cfg_pkg::ORIENT_ANGLE_RESET;
      flat_angle_reg   <= cfg_pkg::FLAT_ANGLE_RESET;
      flat_hold_reg    <= cfg_pkg::FLAT_HOLD_RESET;
      queue_wm_reg     <= cfg_pkg::QUEUE_WM_RESET;
      selftest_reg     <= cfg_pkg::SELFTEST_RESET;
    end else if (i_wr_en) begin
      unique case (i_addr)
        cfg_pkg::ORIENT_SETUP_ADDR: orient_setup_reg <= i_wdata & cfg_pkg::ORIENT_SETUP_MASK;
        cfg_pkg::ORIENT_ANGLE_ADDR: orient_angle_reg <= i_wdata & cfg_pkg::ORIENT_ANGLE_MASK;
        cfg_pkg::FLAT_ANGLE_ADDR:   flat_angle_reg   <= i_wdata & cfg_pkg::FLAT_ANGLE_MASK;
        cfg_pkg::FLAT_HOLD_ADDR:    flat_hold_reg    <= i_wdata & cfg_pkg::FLAT_HOLD_MASK;
        cfg_pkg::QUEUE_WM_ADDR:     queue_wm_reg     <= i_wdata & cfg_pkg::QUEUE_WM_MASK;
        cfg_pkg::SELFTEST_ADDR:     selftest_reg     <= i_wdata & cfg_pkg::SELFTEST_MASK;
        default: ;
      endcase
    end
  end

  // reads; reserved bits and unmapped addresses give zero
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) o_rdata <= 8'h00;
    else if (i_rd_en) begin
      unique case (i_addr)
        cfg_pkg::ORIENT_SETUP_ADDR: o_rdata <= orient_setup_reg;
        cfg_pkg::ORIENT_ANGLE_ADDR: o_rdata <= orient_angle_reg;
        cfg_pkg::FLAT_ANGLE_ADDR:   o_rdata <= flat_angle_reg;
        cfg_pkg::FLAT_HOLD_ADDR:    o_rdata <= flat_hold_reg;
        cfg_pkg::QUEUE_WM_ADDR:     o_rdata <= queue_wm_reg;
        cfg_pkg::SELFTEST_ADDR:     o_rdata <= selftest_reg;
        default:                    o_rdata <= 8'h00;
      endcase
    end
  end

  assign block_mode               = orient_setup_reg[cfg_pkg::BLOCK_POS +: 2];
  assign updown_change_irq_enable = orient_angle_reg[cfg_pkg::UD_EN_POS];
  assign level_hysteresis         = flat_hold_reg[cfg_pkg::LEVEL_HY_POS +: 3];
  assign wm_level                 = queue_wm_reg[cfg_pkg::WM_POS +: 6];
  assign st_axis                  = selftest_reg[cfg_pkg::AXIS_POS +: 2];

  // engine-facing fields; engine scales each step itself
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_orient_hyst  <= 3'h0;
      o_orient_mode  <= 2'h0;
      o_orient_theta <= 6'h0;
      o_flat_theta   <= 6'h0;
    end else begin
      o_orient_hyst  <= orient_setup_reg[cfg_pkg::HYST_POS +: 3];
      o_orient_mode  <= orient_setup_reg[cfg_pkg::MODE_POS +: 2];
      o_orient_theta <= orient_angle_reg[cfg_pkg::THETA_POS +: 6];
      o_flat_theta   <= flat_angle_reg[cfg_pkg::THETA_POS +: 6];
    end
  end

  always_comb begin
    unique case (block_mode)
      2'h0: blocked = 1'b0;
      2'h1: blocked = i_theta_block || i_accel_15g;
      2'h2: blocked = i_theta_block || i_slope_02g || i_accel_15g;
      2'h3: blocked = i_theta_block || i_slope_04g || i_accel_15g || !c.orient_stable;
    endcase
  end

  assign orient_src = i_orient_event || (i_updown_change && updown_change_irq_enable);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) o_orient_irq <= 1'b0;
    else o_orient_irq <= orient_src && !blocked;
  end

  // twice the hysteresis; zero code lets any movement through
  assign flat_limit  = {5'h0, level_hysteresis, 1'b0};
  assign flat_change = i_flat_event && ({1'b0, i_flat_delta} > flat_limit);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) flat_pend_reg <= 1'b0;
    else if (flat_change) flat_pend_reg <= 1'b1;
    else if (c.flat_hold_done) flat_pend_reg <= 1'b0;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) o_flat_irq <= 1'b0;
    else o_flat_irq <= flat_pend_reg && c.flat_hold_done;
  end

  // one pulse on reaching the level, not every cycle it is held
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) wm_hit_reg <= 1'b0;
    else wm_hit_reg <= i_fifo_count == {1'b0, wm_level};
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) o_wm_irq <= 1'b0;
    else o_wm_irq <= (i_fifo_count == {1'b0, wm_level}) && !wm_hit_reg;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_st_excite     <= 1'b0;
      o_st_positive   <= 1'b0;
      o_st_high_amp   <= 1'b0;
      o_st_axis_valid <= 3'h7;
      o_st_settled    <= 1'b0;
    end else begin
      o_st_excite   <= st_axis != 2'h0;
      o_st_positive <= selftest_reg[cfg_pkg::SIGN_POS];
      o_st_high_amp <= selftest_reg[cfg_pkg::AMP_POS];
      o_st_settled  <= c.selftest_settled;
      unique case (st_axis)
        2'h0: o_st_axis_valid <= 3'h7;
        2'h1: o_st_axis_valid <= 3'h1;
        2'h2: o_st_axis_valid <= 3'h2;
        2'h3: o_st_axis_valid <= 3'h4;
      endcase
    end
  end

  assign c.hold_code     = flat_hold_reg[cfg_pkg::HOLD_POS +: 2];
  assign c.flat_change   = flat_change;
  assign c.block_mode    = block_mode;
  assign c.orient_change = i_orient_event;
  assign c.axis          = st_axis;

  cfg_timer u_timer (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .c         (c)
  );

  a_block_none: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (block_mode == 2'h0 && i_orient_event) |=> o_orient_irq) else $error("mode 0 blocked");
  a_block_accel: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (block_mode != 2'h0 && i_accel_15g) |=> !o_orient_irq) else $error("1.5g not blocked");
  a_block_slope: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (block_mode == 2'h2 && i_slope_02g) |=> !o_orient_irq) else $error("slope not blocked");
  a_updown_mask: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!updown_change_irq_enable && !i_orient_event) |=> !o_orient_irq) else $error("ud leak");
  a_wm_pulse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_wm_irq |=> !o_wm_irq) else $error("watermark not a pulse");
  a_st_axis_x: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    st_axis == 2'h1 |=> o_st_axis_valid == 3'h1) else $error("x self-test valid");
  a_write_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !i_wr_en |=> $stable(selftest_reg)) else $error("register changed");
  a_level_hysteresis: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_flat_event && {1'b0, i_flat_delta} <= flat_limit) |-> !flat_change)
    else $error("flat change inside band");
  a_sign_map: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_st_positive == $past(selftest_reg[cfg_pkg::SIGN_POS])) else $error("sign");

  c_orient_irq: cover property (@(posedge i_ref_clk) o_orient_irq);
  c_flat_irq:   cover property (@(posedge i_ref_clk) o_flat_irq);
  c_wm_irq:     cover property (@(posedge i_ref_clk) o_wm_irq);
  c_st_settle:  cover property (@(posedge i_ref_clk) o_st_settled);
endmodule : motion_cfg_regs
`default_nettype wire

// File: test/host_model.sv
// host side model: byte writes and reads on the bank's register strobes
`default_nettype none
module host_model (
  input  wire logic       i_ref_clk, // bank clock
  input  wire logic [7:0] i_rdata,   // read data from bank
  output logic            o_wr_en,   // write strobe
  output logic            o_rd_en,   // read strobe
  output logic      [7:0] o_addr,    // register address
  output logic      [7:0] o_wdata    // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  // unmapped places keep all bits so a refused write is really tried
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      cfg_pkg::ORIENT_SETUP_ADDR: return cfg_pkg::ORIENT_SETUP_MASK;
      cfg_pkg::ORIENT_ANGLE_ADDR: return cfg_pkg::ORIENT_ANGLE_MASK;
      cfg_pkg::FLAT_ANGLE_ADDR:   return cfg_pkg::FLAT_ANGLE_MASK;
      cfg_pkg::FLAT_HOLD_ADDR:    return cfg_pkg::FLAT_HOLD_MASK;
      cfg_pkg::QUEUE_WM_ADDR:     return cfg_pkg::QUEUE_WM_MASK;
      cfg_pkg::SELFTEST_ADDR:     return cfg_pkg::SELFTEST_MASK;
      default:                    return 8'hff;
    endcase
  endfunction : wmask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_wr_en <= 1'b1;
    o_addr  <= a;
    o_wdata <= d & wmask(a);
    @(posedge i_ref_clk);
    o_wr_en <= 1'b0;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge i_ref_clk);
    o_rd_en <= 1'b0;
    #1 d = i_rdata;
  endtask : read_reg
endmodule : host_model
`default_nettype wire

// File: test/tb_top.sv
// testbench: register bank readback, field outputs and event qualifiers
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_ref_clk, i_reset, i_wr_en, i_rd_en;
  logic [7:0] i_addr, i_wdata, i_flat_delta, o_rdata, r;
  logic       i_theta_block, i_slope_02g, i_slope_04g, i_accel_15g;
  logic       i_orient_event, i_updown_change, i_flat_event;
  logic [6:0] i_fifo_count;
  logic [2:0] o_orient_hyst, o_st_axis_valid;
  logic [1:0] o_orient_mode;
  logic [5:0] o_orient_theta, o_flat_theta;
  logic       o_orient_irq, o_flat_irq, o_wm_irq;
  logic       o_st_excite, o_st_positive, o_st_high_amp, o_st_settled;
  logic [7:0] adr [6];
  logic [7:0] rv  [6];
  logic [7:0] v   [6];
  int         fail_count, comparisons, seed, k, j, b, c, h, no, nf;
  motion_cfg_regs dut (.i_ref_clk, .i_reset, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
    .i_theta_block, .i_slope_02g, .i_slope_04g, .i_accel_15g, .i_orient_event,
    .i_updown_change, .i_flat_delta, .i_flat_event, .i_fifo_count, .o_rdata,
    .o_orient_hyst, .o_orient_mode, .o_orient_theta, .o_flat_theta, .o_orient_irq,
    .o_flat_irq, .o_wm_irq, .o_st_axis_valid, .o_st_excite, .o_st_positive,
    .o_st_high_amp, .o_st_settled);
  host_model host (.i_ref_clk, .i_rdata(o_rdata), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wdata(i_wdata));
  function automatic logic exp_orient(input int bm, input int cond);
    case (bm)
      0:       return 1'b1;
      1:       return !(cond == 1 || cond == 4);
      2:       return !(cond == 1 || cond == 2 || cond == 4);
      default: return 1'b0;
    endcase
  endfunction : exp_orient
  function automatic logic [2:0] exp_valid(input logic [1:0] a);
    return (a == 2'h0) ? 3'h7 : 3'(3'h1 << (a - 2'h1));
  endfunction : exp_valid
  task complete_run;
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // one-cycle event pulse, then irq pulses counted over a short window
  task automatic fire(input logic [2:0] s, output int n_or, output int n_fl);
    int i;
    @(posedge i_ref_clk);
    {i_flat_event, i_updown_change, i_orient_event} <= s;
    @(posedge i_ref_clk);
    {i_flat_event, i_updown_change, i_orient_event} <= 3'h0;
    n_or = 0;
    n_fl = 0;
    for (i = 0; i < 6; i++) begin
      #1 n_or += int'(o_orient_irq === 1'b1);
      n_fl += int'(o_flat_irq === 1'b1);
      @(posedge i_ref_clk);
    end
  endtask : fire
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    fail_count++;
    complete_run;
  end
  initial begin
    seed = 27;
    i_reset = 1'b1;
    {i_theta_block, i_slope_02g, i_slope_04g, i_accel_15g} = 4'h0;
    {i_orient_event, i_updown_change, i_flat_event} = 3'h0;
    i_flat_delta = 8'h00;
    i_fifo_count = 7'h7f;
    adr = '{cfg_pkg::ORIENT_SETUP_ADDR, cfg_pkg::ORIENT_ANGLE_ADDR, cfg_pkg::FLAT_ANGLE_ADDR,
            cfg_pkg::FLAT_HOLD_ADDR, cfg_pkg::QUEUE_WM_ADDR, cfg_pkg::SELFTEST_ADDR};
    rv = '{cfg_pkg::ORIENT_SETUP_RESET, cfg_pkg::ORIENT_ANGLE_RESET, cfg_pkg::FLAT_ANGLE_RESET,
           cfg_pkg::FLAT_HOLD_RESET, cfg_pkg::QUEUE_WM_RESET, cfg_pkg::SELFTEST_RESET};
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    for (k = 0; k < 6; k++) begin
      host.read_reg(adr[k], r);
      `CHK(r, rv[k])
    end
    `CHK(o_st_axis_valid, 3'h7)
    `CHK(o_orient_hyst, rv[0][6:4])
    host.write_reg(8'h31, 8'hff);
    host.read_reg(8'h31, r);
    `CHK(r, 8'h00)
    // every threshold mode and self-test axis code once, other bits random
    for (k = 0; k < 4; k++) begin
      for (j = 0; j < 6; j++)
        v[j] = 8'($random(seed)) & host.wmask(adr[j]);
      v[0][1:0] = 2'(k);
      v[5][1:0] = 2'(k);
      for (j = 0; j < 6; j++)
        host.write_reg(adr[j], v[j]);
      for (j = 0; j < 6; j++) begin
        host.read_reg(adr[j], r);
        `CHK(r, v[j])
      end
      `CHK(o_orient_hyst, v[0][6:4])
      `CHK(o_orient_mode, v[0][1:0])
      `CHK(o_orient_theta, v[1][5:0])
      `CHK(o_flat_theta, v[2][5:0])
      `CHK(o_st_axis_valid, exp_valid(v[5][1:0]))
      `CHK(o_st_excite, (v[5][1:0] != 2'h0))
      `CHK(o_st_positive, v[5][2])
      `CHK(o_st_high_amp, v[5][3])
      `CHK(o_st_settled, 1'b0)
    end
    host.write_reg(cfg_pkg::ORIENT_ANGLE_ADDR, 8'h48);
    for (b = 0; b < 4; b++) begin
      host.write_reg(cfg_pkg::ORIENT_SETUP_ADDR, 8'(b << 2));
      for (c = 0; c < 5; c++) begin
        {i_accel_15g, i_slope_04g, i_slope_02g, i_theta_block} <= 4'((c == 0) ? 0 : 1 << (c - 1));
        fire(3'h1, no, nf);
        `CHK(no, int'(exp_orient(b, c)))
      end
    end
    {i_accel_15g, i_slope_04g, i_slope_02g, i_theta_block} <= 4'h0;
    host.write_reg(cfg_pkg::ORIENT_SETUP_ADDR, 8'h00);
    for (j = 0; j < 2; j++) begin
      host.write_reg(cfg_pkg::ORIENT_ANGLE_ADDR, (j == 1) ? 8'h48 : 8'h08);
      fire(3'h2, no, nf);
      `CHK(no, j)
    end
    // hold code zero: longer holds would need millions of cycles
    for (j = 0; j < 2; j++) begin
      h = (j == 1) ? (($random(seed) & 7) | 1) : 0;
      host.write_reg(cfg_pkg::FLAT_HOLD_ADDR, 8'(h));
      for (c = 0; c < 2; c++) begin
        i_flat_delta <= 8'(2 * h + c);
        fire(3'h4, no, nf);
        `CHK(nf, c)
      end
    end
    h = ($random(seed) & 63) | 1;
    host.write_reg(cfg_pkg::QUEUE_WM_ADDR, 8'(h));
    @(posedge i_ref_clk);
    i_fifo_count <= 7'(h - 1);
    @(posedge i_ref_clk);
    i_fifo_count <= 7'(h);
    nf = 0;
    for (k = 0; k < 8; k++) begin
      #1 nf += int'(o_wm_irq === 1'b1);
      @(posedge i_ref_clk);
    end
    `CHK(nf, 1)
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
